// ### shared/cosix_consts.svh
// offsets, field positions, reset values and codes for the output-six control block
`ifndef COSIX_CONSTS_SVH
`define COSIX_CONSTS_SVH

// register index as printed, byte address is four times it
`define COSIX_CTRL_INDEX 8'h16
`define COSIX_CTRL_ADDR 10'h058
`define COSIX_ADDR_W 10

// field positions inside the control byte
`define COSIX_PDN_BIT 7
`define COSIX_PLL_A_FEEDBACK_INTEGER_MODE_BIT 6
`define COSIX_PLL_SEL_BIT 5
`define COSIX_INV_BIT 4
`define COSIX_SRC_HI 3
`define COSIX_SRC_LO 2
`define COSIX_DRV_HI 1
`define COSIX_DRV_LO 0

// reset value of the control byte: output powered up, crystal source, 2 mA
`define COSIX_CTRL_RESET 8'h00

// drive strength in milliamps per code
`define COSIX_DRV_MA_0 4'h2
`define COSIX_DRV_MA_1 4'h4
`define COSIX_DRV_MA_2 4'h6
`define COSIX_DRV_MA_3 4'h8

`endif

// ### shared/cosix_pkg.sv
// types for the output-six control block
`default_nettype none
package cosix_pkg;
  // output source codes
  typedef enum logic [1:0] {
    SRC_CRYSTAL = 2'h0,
    SRC_CLOCK_INPUT_PIN = 2'h1,
    SRC_RESERVED = 2'h2,
    SRC_DIVIDER_ZERO = 2'h3
  } cosix_source_type;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } cosix_bus_state_type;
endpackage : cosix_pkg
`default_nettype wire

// ### logic/cosix_clock_mux.sv
// clock selection, inversion and power-down for output six
`default_nettype none
module cosix_clock_mux
(
  // clocks to choose among
  input wire logic crystal_clk_i,
  input wire logic clock_input_pin_i,
  input wire logic divider_zero_clk_i,
  // settings
  input wire cosix_pkg::cosix_source_type source_i,
  input wire logic invert_i,
  input wire logic power_down_i,
  // output
  output logic clock_output_six_o
);
  logic picked;

  // combinational path: the selected clock is passed, not resampled, so its edges survive
  always_comb
  begin
    unique case (source_i)
      cosix_pkg::SRC_CRYSTAL: picked = crystal_clk_i;
      cosix_pkg::SRC_CLOCK_INPUT_PIN: picked = clock_input_pin_i;
      cosix_pkg::SRC_DIVIDER_ZERO: picked = divider_zero_clk_i;
      default: picked = 1'b0; // reserved code gives a quiet output
    endcase
  end

  // a powered-down driver holds low
  assign clock_output_six_o = power_down_i ? 1'b0 : (picked ^ invert_i);
endmodule : cosix_clock_mux
`default_nettype wire

// ### logic/cosix_ctrl.sv
// output-six clock control register with its wishbone slave and output stage
//
// Contract
// - Bit 7 set powers the output-six driver down, cleared keeps it powered up.
// - Bit 5 selects pll a (0) or pll b (1) to feed the output-six fractional divider.
// - Bit 4 set inverts the output-six clock, cleared passes it unchanged.
// - Source code 00 drives output six straight from the crystal oscillator.
// - Source code 01 makes output six a buffered copy of the clock input pin.
// - Source code 11 drives output six from fractional divider zero.
// - Drive codes 00 to 11 select 2, 4, 6 and 8 mA of drive strength.
//
// Local design decision: the Wishbone interface to the registers.
`include "cosix_consts.svh"
`default_nettype none
module cosix_ctrl
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`COSIX_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clocks to route
  input wire logic crystal_clk_i,
  input wire logic clock_input_pin_i,
  input wire logic divider_zero_clk_i,
  // controls toward the synthesis and driver stages
  output logic out_six_power_down_o,
  output logic out_six_divider_pll_select_o,
  output logic pll_a_feedback_integer_mode_o,
  output logic out_six_invert_o,
  output logic [1:0] out_six_source_select_o,
  output logic [1:0] out_six_drive_strength_o,
  output logic [3:0] out_six_drive_milliamps_o,
  // the routed clock
  output logic clock_output_six_o
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [3:0] ma_reg;
  cosix_pkg::cosix_bus_state_type state_reg;
  logic hit;
  logic wr_go;
  logic mux_clk;

  // milliamps for a drive code
  function automatic logic [3:0] drive_ma(input logic [1:0] code);
    unique case (code)
      2'h0: drive_ma = `COSIX_DRV_MA_0;
      2'h1: drive_ma = `COSIX_DRV_MA_1;
      2'h2: drive_ma = `COSIX_DRV_MA_2;
      default: drive_ma = `COSIX_DRV_MA_3;
    endcase
  endfunction : drive_ma

  assign hit = (wb_adr_i == `COSIX_CTRL_ADDR);
  // the write lands at the edge where the master sees ack, so a request dropped before its answer writes nothing
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && hit && (state_reg == cosix_pkg::ST_ACK);

  // next control byte: only lane 0 carries it, other lanes are ignored
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_go && wb_sel_i[0])
    begin
      ctrl_next = wb_dat_i[7:0];
    end
  end

  // control byte store; reserved source code is kept as written, software must avoid it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= `COSIX_CTRL_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // bus handshake: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= cosix_pkg::ST_IDLE;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        cosix_pkg::ST_IDLE:
        begin
          if (wb_cyc_i && wb_stb_i)
          begin
            state_reg <= cosix_pkg::ST_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        cosix_pkg::ST_ACK:
        begin
          state_reg <= cosix_pkg::ST_IDLE;
          wb_ack_o <= 1'b0;
        end
        default:
        begin
          state_reg <= cosix_pkg::ST_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  // read data: unmapped addresses read zero, ack is still given so the bus never hangs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (wb_cyc_i && wb_stb_i && !wb_we_i && state_reg == cosix_pkg::ST_IDLE)
    begin
      wb_dat_o <= hit ? {24'h00_0000, ctrl_reg} : 32'h0000_0000;
    end
  end

  // power-down bit; fed from the next value so every field output lines up with the stored byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_six_power_down_o <= 1'b0;
    end
    else
    begin
      out_six_power_down_o <= ctrl_next[`COSIX_PDN_BIT];
    end
  end

  // integer mode for the pll a feedback divider, passed on as written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pll_a_feedback_integer_mode_o <= 1'b0;
    end
    else
    begin
      pll_a_feedback_integer_mode_o <= ctrl_next[`COSIX_PLL_A_FEEDBACK_INTEGER_MODE_BIT];
    end
  end

  // pll choice for the output-six fractional divider: 0 pll a, 1 pll b
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_six_divider_pll_select_o <= 1'b0;
    end
    else
    begin
      out_six_divider_pll_select_o <= ctrl_next[`COSIX_PLL_SEL_BIT];
    end
  end

  // invert bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_six_invert_o <= 1'b0;
    end
    else
    begin
      out_six_invert_o <= ctrl_next[`COSIX_INV_BIT];
    end
  end

  // source field, reported as stored; the reserved code is shown too
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_six_source_select_o <= 2'h0;
    end
    else
    begin
      out_six_source_select_o <= ctrl_next[`COSIX_SRC_HI:`COSIX_SRC_LO];
    end
  end

  // drive code toward the output driver
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_six_drive_strength_o <= 2'h0;
    end
    else
    begin
      out_six_drive_strength_o <= ctrl_next[`COSIX_DRV_HI:`COSIX_DRV_LO];
    end
  end

  // drive current in milliamps, decoded once here rather than in every consumer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ma_reg <= `COSIX_DRV_MA_0;
    end
    else
    begin
      ma_reg <= drive_ma(ctrl_next[`COSIX_DRV_HI:`COSIX_DRV_LO]);
    end
  end
  assign out_six_drive_milliamps_o = ma_reg;

  // output stage; the clock path is not a flip-flop by nature, retiming would halve it
  cosix_clock_mux u_mux
  (
    .crystal_clk_i(crystal_clk_i),
    .clock_input_pin_i(clock_input_pin_i),
    .divider_zero_clk_i(divider_zero_clk_i),
    .source_i(cosix_pkg::cosix_source_type'(ctrl_reg[`COSIX_SRC_HI:`COSIX_SRC_LO])),
    .invert_i(ctrl_reg[`COSIX_INV_BIT]),
    .power_down_i(ctrl_reg[`COSIX_PDN_BIT]),
    .clock_output_six_o(mux_clk)
  );
  assign clock_output_six_o = mux_clk;
endmodule : cosix_ctrl
`default_nettype wire

// ### bench/cosix_ctrl_monitor.sv
// port assertions for the output-six control block
`include "cosix_consts.svh"
`default_nettype none
module cosix_ctrl_monitor
(
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`COSIX_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // routed clocks and field outputs
  input wire logic crystal_clk_i,
  input wire logic clock_input_pin_i,
  input wire logic divider_zero_clk_i,
  input wire logic out_six_power_down_o,
  input wire logic out_six_divider_pll_select_o,
  input wire logic pll_a_feedback_integer_mode_o,
  input wire logic out_six_invert_o,
  input wire logic [1:0] out_six_source_select_o,
  input wire logic [1:0] out_six_drive_strength_o,
  input wire logic [3:0] out_six_drive_milliamps_o,
  input wire logic clock_output_six_o
);
  // a new request is one the slave has not yet answered
  wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // the edge at which the master sees ack; writes land there
  wire logic done = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire logic hit = wb_adr_i == `COSIX_CTRL_ADDR;
  wire logic [7:0] f = {out_six_power_down_o, pll_a_feedback_integer_mode_o, out_six_divider_pll_select_o,
    out_six_invert_o, out_six_source_select_o, out_six_drive_strength_o};
  wire logic s = clock_output_six_o;
  wire logic live = ~out_six_power_down_o;
  wire logic inv = out_six_invert_o;
  wire logic [1:0] src = out_six_source_select_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_single_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  write_store_a: assert property (done && wb_we_i && hit && wb_sel_i[0] |=> f == $past(wb_dat_i[7:0]))
    else $error("write not stored");
  read_back_a: assert property (req && !wb_we_i |=> wb_dat_o == (hit ? {24'h0, f} : 32'h0))
    else $error("read data wrong");
  power_down_low_a: assert property (out_six_power_down_o |-> !s) else $error("output not off");
  crystal_path_a: assert property (live && src == 2'h0 |-> s == (crystal_clk_i ^ inv))
    else $error("crystal path wrong");
  pin_path_a: assert property (live && src == 2'h1 |-> s == (clock_input_pin_i ^ inv))
    else $error("input pin path wrong");
  divider_path_a: assert property (live && src == 2'h3 |-> s == (divider_zero_clk_i ^ inv))
    else $error("divider path wrong");
  drive_ma_a: assert property (out_six_drive_milliamps_o == {1'b0, out_six_drive_strength_o, 1'b0} + 4'h2)
    else $error("drive current wrong");
  pll_sel_cause_a: assert property ($rose(f[5]) |-> $past(done && wb_we_i && hit && wb_dat_i[5]))
    else $error("pll select changed alone");
endmodule : cosix_ctrl_monitor
bind cosix_ctrl cosix_ctrl_monitor mon (.*);
`default_nettype wire

// ### bench/cosix_ctrl_test.sv
// self-checking bench for the output-six control block
`include "cosix_consts.svh"
`default_nettype none
module cosix_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [`COSIX_ADDR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic crystal_clk_i = 1'b0, clock_input_pin_i = 1'b0, divider_zero_clk_i = 1'b0, clock_output_six_o;
  logic out_six_power_down_o, out_six_divider_pll_select_o, pll_a_feedback_integer_mode_o, out_six_invert_o;
  logic [1:0] out_six_source_select_o, out_six_drive_strength_o;
  logic [3:0] out_six_drive_milliamps_o;
  int miscompares = 0, num_checks = 0;
  wire logic [7:0] f = {out_six_power_down_o, pll_a_feedback_integer_mode_o, out_six_divider_pll_select_o,
    out_six_invert_o, out_six_source_select_o, out_six_drive_strength_o};
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  cosix_ctrl dut (.*);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one classic cycle; the read data is taken at the ack edge
  task automatic bus(input logic we, input logic [9:0] adr, input logic [3:0] sel, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, d};
    // no cycle limit here: only the watchdog ends a wait
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic test_fields();
    logic [7:0] v;
    @(negedge clk_i);
    check(f, 8'h0);
    check(clock_output_six_o, crystal_clk_i);
    for (int i = 0; i < 9; i++)
    begin
      v = (i == 8) ? 8'hff : (8'h1 << i) | 8'(i[1:0]) | ((i == 3) ? 8'h04 : 8'h00); // source never 10
      bus(1'b1, `COSIX_CTRL_ADDR, 4'h1, v);
      // fields settle at the ack edge, so look half a cycle later
      @(negedge clk_i);
      check(f, v);
      check(out_six_drive_milliamps_o, {1'b0, v[1:0], 1'b0} + 4'h2);
      bus(1'b0, `COSIX_CTRL_ADDR, 4'hf, 8'h0);
      check(rd, {24'h0, v});
    end
    $display("test_fields done");
  endtask : test_fields
  // every legal source, inverted or not, powered or not, against all clock levels
  task automatic test_route();
    for (int c = 0; c < 16; c++)
    begin
      if (c[1:0] == 2'h2) continue; // reserved code is never written
      bus(1'b1, `COSIX_CTRL_ADDR, 4'h1, {c[3], 2'b0, c[2], c[1:0], 2'b0});
      for (int p = 0; p < 8; p++)
      begin
        @(posedge clk_i);
        {divider_zero_clk_i, clock_input_pin_i, crystal_clk_i} <= p[2:0];
        @(negedge clk_i);
        check(clock_output_six_o, c[3] ? 1'b0 : p[c[1:0] == 2'h3 ? 2 : c[0]] ^ c[2]);
      end
    end
    $display("test_route done");
  endtask : test_route
  // unmapped address and disabled byte lane leave the register alone
  task automatic test_refused();
    bus(1'b1, `COSIX_CTRL_ADDR, 4'h1, 8'ha5);
    bus(1'b1, 10'h05c, 4'h1, 8'h5f);
    bus(1'b1, `COSIX_CTRL_ADDR, 4'he, 8'h5f);
    bus(1'b0, 10'h05c, 4'hf, 8'h0);
    check(rd, 32'h0);
    bus(1'b0, `COSIX_CTRL_ADDR, 4'hf, 8'h0);
    check(rd, 32'h0000_00a5);
    check(f, 8'ha5);
    $display("test_refused done");
  endtask : test_refused
  // a reset in mid-run brings every field back to its reset value
  task automatic test_reset();
    bus(1'b1, `COSIX_CTRL_ADDR, 4'h1, 8'hf3);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check(f, `COSIX_CTRL_RESET);
    check(out_six_drive_milliamps_o, `COSIX_DRV_MA_0);
    bus(1'b0, `COSIX_CTRL_ADDR, 4'hf, 8'h0);
    check(rd, {24'h00_0000, `COSIX_CTRL_RESET});
    $display("test_reset done");
  endtask : test_reset
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    test_fields();
    test_route();
    test_refused();
    test_reset();
    report_and_stop();
  end
endmodule : cosix_ctrl_test
`default_nettype wire
